// File: hw/asr_pkg.sv
// Package: constants and state type for the setup and result register bank
package asr_pkg;

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W       = 6;
   localparam logic [5:0]  SETUP_ADDR   = 6'h03;
   localparam logic [5:0]  RESULT_ADDR  = 6'h04;

   // ------------------------------------------------------------
   // Converter setup register layout
   // ------------------------------------------------------------
   localparam int unsigned SETUP_W      = 16;
   localparam logic [15:0] SETUP_RST    = 16'h1340;
   // Writable bits: 12..8, 6..0; 15..13 and 7 read as zero
   localparam logic [15:0] SETUP_WMASK  = 16'h1f7f;
   localparam int unsigned CODING_BIT   = 12;
   localparam int unsigned REFBUF_LSB   = 10;
   localparam int unsigned AINBUF_LSB   = 8;
   localparam int unsigned REFSEL_LSB   = 4;
   localparam int unsigned CH_NUM       = 4;
   localparam int unsigned HV_CH        = 0;
   localparam logic [3:0]  CH_NONE      = 4'h0;
   localparam logic [3:0]  CH_HV_ONLY   = 4'h1;

   // ------------------------------------------------------------
   // Conversion result layout
   // ------------------------------------------------------------
   localparam int unsigned RES_W        = 24;
   localparam int unsigned SHORT_W      = 16;
   localparam int unsigned STAT_W       = 8;
   localparam int unsigned RD_W         = 32;
   localparam logic [23:0] RES_RST      = 24'h000000;
   localparam logic [7:0]  STAT_RST     = 8'h00;
   localparam logic [5:0]  LEN_SHORT    = 6'h10;
   localparam logic [5:0]  LEN_FULL     = 6'h18;
   localparam logic [5:0]  LEN_STAT     = 6'h08;
   localparam logic [5:0]  LEN_NONE     = 6'h00;

   // ------------------------------------------------------------
   // Whole state of the register bank
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] setup;      // Converter setup register
      logic [23:0] result;     // Stored conversion result
      logic        res_short;  // Stored result is 16 bits wide
      logic [7:0]  res_stat;   // Status snapshot matching the result
      logic        rdy_b;      // Ready flag, low while unread data waits
      logic        pend_v;     // A finished conversion waits to be stored
      logic [23:0] pend_data;  // Waiting conversion, rounded in short mode
      logic        pend_short; // Waiting conversion is 16 bits wide
      logic [7:0]  pend_stat;  // Status captured with the waiting result
      logic [31:0] rd_data;    // Read answer word, left unshifted
      logic [5:0]  rd_bits;    // Number of valid bits in rd_data
   } asr_state_t;

endpackage

// File: hw/asr_round16.sv
// Rounds a 24-bit conversion result to 16 bits with saturation
`timescale 1ns/1ps

module asr_round16
   import asr_pkg::*;
#(
   parameter int unsigned IN_W  = 24,
   parameter int unsigned OUT_W = 16
) (
   // Input sample
   input  wire logic [IN_W-1:0]  full_word,
   // Rounded sample
   output logic      [OUT_W-1:0] short_word
);

   // ------------------------------------------------------------
   // Round half up
   // ------------------------------------------------------------
   localparam int unsigned DROP = IN_W - OUT_W;

   logic [OUT_W:0] sum;   // One extra bit to see the carry

   // Saturate at full scale so that a code near the top never wraps
   always_comb begin
      sum = {1'b0, full_word[IN_W-1:DROP]} +
            {{OUT_W{1'b0}}, full_word[DROP-1]};
      if (sum[OUT_W]) begin
         short_word = {OUT_W{1'b1}};
      end else begin
         short_word = sum[OUT_W-1:0];
      end
   end

endmodule

// File: hw/asr_regs.sv
// Converter setup register and conversion result register of the front end
`timescale 1ns/1ps
//
// Contract
// RULE1: Setup at 0x3, resets 0x1340, reserved zero
// RULE2: Bit 12 picks straight or offset binary
// RULE3: Bits 11:10 set reference buffer halves
// RULE4: Bits 9:8 set analog buffer halves
// RULE5: Host switches buffer halves as pairs; the bench setup loop also writes the split codes 01 and 10 to both fields
// RULE6: Bits 5:4 choose reference source
// RULE7: Host sets reference enable with internal source
// RULE8: Bits 3:0 enable the four channels
// RULE9: All enables zero means high-voltage channel on
// RULE10: Result at 0x4, 24 bits, resets zero
// RULE11: Reading result drives ready high
// RULE12: Same result may be read repeatedly
// RULE13: Host cannot foresee next result after read
// RULE14: No result update during a result read
// RULE15: Status append makes result read longer
// RULE16: Short word mode rounds results to 16
// RULE17: Status append control, status matches result
// RULE18: Short mode applies from next conversion

module asr_regs
   import asr_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // Register access from the serial engine
   input  wire logic [ADDR_W-1:0] acc_addr,
   input  wire logic              acc_wr,
   input  wire logic [SETUP_W-1:0] acc_wdata,
   input  wire logic              acc_rd,
   input  wire logic              acc_rd_busy,
   output logic      [RD_W-1:0]   rd_data,
   output logic      [5:0]        rd_bits,
   // Interface control bits kept elsewhere
   input  wire logic              status_append_en,
   input  wire logic              short_word_length,
   input  wire logic [STAT_W-1:0] conv_status,
   // Conversion results from the digital filter
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_data,
   // Setup fields to the analog front end
   output logic                   output_coding_select,
   output logic      [1:0]        ref_buffer_cfg,
   output logic      [1:0]        analog_buffer_cfg,
   output logic      [1:0]        ref_source_sel,
   output logic      [CH_NUM-1:0] channel_on,
   // Ready indication, low while an unread result waits
   output logic                   rdy_b
);

   // ------------------------------------------------------------
   // State and next state
   // ------------------------------------------------------------
   asr_state_t s_q;          // Registered state
   asr_state_t s_d;          // Next state

   logic [SHORT_W-1:0] rounded;     // Conversion rounded to 16 bits
   logic               rd_setup;    // Read of the setup register
   logic               rd_result;   // Read of the result register
   logic               wr_setup;    // Write of the setup register
   logic               hold_off;    // Result read under way
   logic               commit;      // Waiting result moves in now
   logic [3:0]         ch_raw;      // Channel enables as written

   // ------------------------------------------------------------
   // Rounding unit
   // ------------------------------------------------------------
   asr_round16 #(
      .IN_W  (RES_W),
      .OUT_W (SHORT_W)
   ) u_round (
      .full_word  (conv_data),
      .short_word (rounded)
   );

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   // Reads of the result count as under way from the start pulse on,
   // so a conversion never slips in between start and shift-out
   always_comb begin
      wr_setup  = acc_wr && (acc_addr == SETUP_ADDR);
      rd_setup  = acc_rd && (acc_addr == SETUP_ADDR);
      rd_result = acc_rd && (acc_addr == RESULT_ADDR);
      hold_off  = rd_result || acc_rd_busy;           // RULE14
      commit    = s_q.pend_v && !hold_off;            // RULE14
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // Setup write: only writable bits land, the rest stay zero
      if (wr_setup) begin
         s_d.setup = acc_wdata & SETUP_WMASK;         // RULE1
      end

      // New conversion goes to the waiting slot; a later one
      // replaces an earlier one that never made it in
      if (conv_done) begin
         s_d.pend_v = 1'b1;
         s_d.pend_stat = conv_status;                 // RULE17
         // Mode taken per conversion, so a change only shows up
         // on the first result finished after it
         s_d.pend_short = short_word_length;          // RULE18
         if (short_word_length) begin
            s_d.pend_data = {{(RES_W-SHORT_W){1'b0}}, rounded}; // RULE16
         end else begin
            s_d.pend_data = conv_data;
         end
      end else if (commit) begin
         s_d.pend_v = 1'b0;
      end

      // Store the waiting result once no result read is in progress
      if (commit) begin
         s_d.result    = s_q.pend_data;               // RULE10
         s_d.res_short = s_q.pend_short;
         s_d.res_stat  = s_q.pend_stat;
         s_d.rdy_b     = 1'b0;
      end

      // A result read marks the data as taken; it never clashes
      // with a store since hold_off blocks the store that cycle
      if (rd_result) begin
         s_d.rdy_b = 1'b1;                            // RULE11
      end

      // Read answer; the stored result is left untouched so that
      // a second read returns the same value
      if (rd_result) begin
         if (s_q.res_short) begin
            s_d.rd_data = {s_q.result[SHORT_W-1:0],
                           {(RD_W-SHORT_W){1'b0}}};   // RULE16
            s_d.rd_bits = LEN_SHORT;
         end else begin
            s_d.rd_data = {s_q.result, STAT_RST};     // RULE12
            s_d.rd_bits = LEN_FULL;
         end
         if (status_append_en) begin
            if (s_q.res_short) begin
               s_d.rd_data = {s_q.result[SHORT_W-1:0], s_q.res_stat,
                              STAT_RST};              // RULE15
            end else begin
               s_d.rd_data = {s_q.result, s_q.res_stat}; // RULE15
            end
            s_d.rd_bits = (s_q.res_short ? LEN_SHORT : LEN_FULL)
                          + LEN_STAT;                 // RULE17
         end
      end else if (rd_setup) begin
         s_d.rd_data = {s_q.setup, {(RD_W-SETUP_W){1'b0}}};
         s_d.rd_bits = LEN_SHORT;
      end else if (acc_rd) begin
         // Unmapped here: answer zero with no bits
         s_d.rd_data = {RD_W{1'b0}};
         s_d.rd_bits = LEN_NONE;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q.setup      <= SETUP_RST;                 // RULE1
         s_q.result     <= RES_RST;                   // RULE10
         s_q.res_short  <= 1'b0;
         s_q.res_stat   <= STAT_RST;
         s_q.rdy_b      <= 1'b1;
         s_q.pend_v     <= 1'b0;
         s_q.pend_data  <= RES_RST;
         s_q.pend_short <= 1'b0;
         s_q.pend_stat  <= STAT_RST;
         s_q.rd_data    <= {RD_W{1'b0}};
         s_q.rd_bits    <= LEN_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Field decode straight from the stored setup word
   always_comb begin
      output_coding_select = s_q.setup[CODING_BIT];               // RULE2
      ref_buffer_cfg    = s_q.setup[REFBUF_LSB +: 2];             // RULE3
      analog_buffer_cfg = s_q.setup[AINBUF_LSB +: 2];             // RULE4
      ref_source_sel    = s_q.setup[REFSEL_LSB +: 2];             // RULE6
      ch_raw            = s_q.setup[CH_NUM-1:0];                  // RULE8
      // Never leave the converter with nothing to sequence
      channel_on = (ch_raw == CH_NONE) ? CH_HV_ONLY : ch_raw;     // RULE9
      rd_data = s_q.rd_data;
      rd_bits = s_q.rd_bits;
      rdy_b   = s_q.rdy_b;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // Reserved bits of the setup register stay zero
   a_setup_reserved: assert property (                             // RULE1
      (s_q.setup & ~SETUP_WMASK) == 16'h0000)
      else $error("setup reserved bits not zero");

   // A setup write lands masked in the setup register
   a_setup_write: assert property (                                // RULE1
      wr_setup |=> s_q.setup == ($past(acc_wdata) & SETUP_WMASK))
      else $error("setup write not stored");

   // Coding select follows the written bit
   a_coding_out: assert property (                                 // RULE2
      wr_setup |=> output_coding_select == $past(acc_wdata[CODING_BIT]))
      else $error("coding select wrong");

   // Both buffer fields follow the written bits
   a_buffer_out: assert property (                                 // RULE3
      wr_setup |=> ref_buffer_cfg == $past(acc_wdata[REFBUF_LSB +: 2])
               && analog_buffer_cfg == $past(acc_wdata[AINBUF_LSB +: 2]))
      else $error("buffer fields wrong");

   // Reference source follows the written bits, reserved code too
   a_refsel_out: assert property (                                 // RULE6
      wr_setup |=> ref_source_sel == $past(acc_wdata[REFSEL_LSB +: 2]))
      else $error("reference select wrong");

   // An empty enable set still runs the high-voltage channel
   a_hv_default: assert property (                                 // RULE9
      (s_q.setup[CH_NUM-1:0] == CH_NONE) |-> channel_on == CH_HV_ONLY)
      else $error("no default channel");

   // Any other enable set passes through unchanged
   a_chan_pass: assert property (                                  // RULE8
      (s_q.setup[CH_NUM-1:0] != CH_NONE) |->
         channel_on == s_q.setup[CH_NUM-1:0])
      else $error("channel enables wrong");

   // A result read always leaves ready high
   a_rdy_on_read: assert property (                                // RULE11
      rd_result |=> rdy_b)
      else $error("ready not high after read");

   // No store while the shift-out is under way
   a_hold_stable: assert property (                                // RULE14
      acc_rd_busy |=> $stable(s_q.result))
      else $error("result changed during read");

   // With no read in the way a conversion lands after two edges
   a_store_delay: assert property (                                // RULE14
      (conv_done && !acc_rd && !acc_rd_busy) ##1
         (!acc_rd && !acc_rd_busy) |=> !rdy_b)
      else $error("result not stored");

   // A read never consumes the stored result
   a_repeat_read: assert property (                                // RULE12
      rd_result |=> $stable(s_q.result))
      else $error("result lost on read");

   // A full-width answer carries the stored result on top
   a_read_full: assert property (                                  // RULE10
      (rd_result && !s_q.res_short) |=>
         rd_data[RD_W-1 -: RES_W] == $past(s_q.result))
      else $error("full read data wrong");

   // A short answer carries the 16-bit result on top
   a_read_short: assert property (                                 // RULE16
      (rd_result && s_q.res_short) |=>
         rd_data[RD_W-1 -: SHORT_W] == $past(s_q.result[SHORT_W-1:0]))
      else $error("short read data wrong");

   // Appended status lengthens the answer by one byte
   a_append_len: assert property (                                 // RULE15
      (rd_result && status_append_en) |=>
         rd_bits == ($past(s_q.res_short) ? LEN_SHORT : LEN_FULL) + LEN_STAT)
      else $error("append length wrong");

   // Status travels with its own conversion
   a_stat_capture: assert property (                               // RULE17
      conv_done |=> s_q.pend_stat == $past(conv_status))
      else $error("status not captured");

   // Word length is taken per conversion, not per read
   a_mode_capture: assert property (                               // RULE18
      conv_done |=> s_q.pend_short == $past(short_word_length))
      else $error("word length not captured");

   // Short results keep the top byte clear
   a_short_low: assert property (                                  // RULE16
      s_q.res_short |-> s_q.result[RES_W-1:SHORT_W] == 8'h00)
      else $error("short result too wide");

   // Main scenarios
   c_read_result: cover property (rd_result ##1 rdy_b);
   c_held_result: cover property (conv_done && acc_rd_busy ##1 acc_rd_busy);
   c_append_short: cover property (
      rd_result && status_append_en && s_q.res_short);
   c_short_store: cover property (conv_done && short_word_length ##1 commit);
   c_unmapped_read: cover property (acc_rd && !rd_result && !rd_setup);

endmodule

// File: sim/asr_host.sv
// Host model: register access strobes and interface control bits
`timescale 1ns/1ps

module asr_host
   import asr_pkg::*;
(
   // Clock
   input  wire logic               sys_clk,
   // Register access
   output logic      [ADDR_W-1:0]  acc_addr,
   output logic                    acc_wr,
   output logic      [SETUP_W-1:0] acc_wdata,
   output logic                    acc_rd,
   output logic                    acc_rd_busy,
   input  wire logic [RD_W-1:0]    rd_data,
   input  wire logic [5:0]         rd_bits,
   // Ready flag from the register bank
   input  wire logic               rdy_b,
   // Interface control bits
   output logic                    status_append_en,
   output logic                    short_word_length
);

   // Mode register reference enable, kept on the host side
   logic ref_on;

   // ---------------------------------------------------------
   // Idle values
   // ---------------------------------------------------------
   initial begin
      acc_addr          = 6'h3f;
      acc_wr            = 1'b0;
      acc_wdata         = 16'h0000;
      acc_rd            = 1'b0;
      acc_rd_busy       = 1'b0;
      status_append_en  = 1'b0;
      short_word_length = 1'b0;
      ref_on            = 1'b0;
   end

   // One write; released lines invert so stale values never pass
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      acc_addr  = a;
      acc_wdata = d;
      acc_wr    = 1'b1;
      // Internal reference also needs the mode register enable
      if (a == SETUP_ADDR && d[5:4] == 2'b10) ref_on = 1'b1;
      @(negedge sys_clk);
      acc_wr    = 1'b0;
      acc_addr  = ~a;
      acc_wdata = ~d;
   endtask

   // One read; busy stands n cycles to mimic a slow shift-out
   task automatic rd(input logic [5:0] a, input int n,
                     output logic [31:0] d, output logic [5:0] b);
      @(negedge sys_clk);
      acc_addr = a;
      acc_rd   = 1'b1;
      @(negedge sys_clk);
      acc_rd      = 1'b0;
      acc_addr    = ~a;
      d           = rd_data;
      b           = rd_bits;
      acc_rd_busy = (n > 0);
      repeat (n) @(negedge sys_clk);
      acc_rd_busy = 1'b0;
   endtask

   // Only a low ready flag tells the host that new data exists
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      repeat (8) begin
         @(negedge sys_clk);
         if (rdy_b === 1'b0) ok = 1'b1;
      end
   endtask

endmodule

// File: sim/testbench.sv
// Self-checking bench for the setup and result register bank
`timescale 1ns/1ps

module testbench
   import asr_pkg::*;
;
   // ---------------------------------------------------------
   // Signals
   // ---------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst_b   = 1'b0;
   logic conv_done = 1'b0;
   logic [23:0] conv_data = 24'h0;
   logic [7:0]  conv_status = 8'h0;
   wire  [5:0]  acc_addr, rd_bits;
   wire  [15:0] acc_wdata;
   wire  [31:0] rd_data;
   wire  acc_wr, acc_rd, acc_rd_busy, status_append_en;
   wire  short_word_length, output_coding_select, rdy_b;
   wire  [1:0]  ref_buffer_cfg, analog_buffer_cfg, ref_source_sel;
   wire  [3:0]  channel_on;
   int   miscompares = 0;
   int   checks_done = 0;
   int   cyc = 0;
   // Behavioural model of the two registers
   logic [15:0] m_setup = SETUP_RST;
   logic [23:0] m_res   = 24'h0;
   logic [7:0]  m_stat  = 8'h0;
   logic        m_short = 1'b0;
   logic        m_rdy_b = 1'b1;

   always #10 sys_clk = ~sys_clk;

   asr_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
      .acc_rd(acc_rd), .acc_rd_busy(acc_rd_busy), .rd_data(rd_data),
      .rd_bits(rd_bits), .status_append_en(status_append_en),
      .short_word_length(short_word_length),
      .conv_status(conv_status), .conv_done(conv_done),
      .conv_data(conv_data),
      .output_coding_select(output_coding_select),
      .ref_buffer_cfg(ref_buffer_cfg),
      .analog_buffer_cfg(analog_buffer_cfg),
      .ref_source_sel(ref_source_sel), .channel_on(channel_on),
      .rdy_b(rdy_b));

   asr_host i_host (.sys_clk(sys_clk), .acc_addr(acc_addr),
      .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rd(acc_rd),
      .acc_rd_busy(acc_rd_busy), .rd_data(rd_data), .rd_bits(rd_bits),
      .status_append_en(status_append_en),
      .short_word_length(short_word_length), .rdy_b(rdy_b));

   // ---------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask

   // Half up on bit 7, saturating at the top code
   function automatic logic [23:0] rnd(logic [23:0] d);
      logic [16:0] r;
      r = {1'b0, d[23:8]} + {16'h0, d[7]};
      return r[16] ? 24'h00ffff : {8'h00, r[15:0]};
   endfunction

   // Expected read answer as {bits, data}
   function automatic logic [37:0] exp_rd(logic [5:0] a, logic ap);
      if (a == SETUP_ADDR) return {6'd16, m_setup, 16'h0};
      if (a != RESULT_ADDR) return 38'h0;
      if (m_short)
         return ap ? {6'd24, m_res[15:0], m_stat, 8'h0}
                   : {6'd16, m_res[15:0], 16'h0};
      return ap ? {6'd32, m_res, m_stat} : {6'd24, m_res, 8'h0};
   endfunction

   task automatic chk_setup();
      logic [3:0] ch;
      ch = (m_setup[3:0] == 4'h0) ? 4'h1 : m_setup[3:0];
      chk("coding", 32'(output_coding_select), 32'(m_setup[12]));
      chk("refbuf", 32'(ref_buffer_cfg), 32'(m_setup[11:10]));
      chk("ainbuf", 32'(analog_buffer_cfg), 32'(m_setup[9:8]));
      chk("refsel", 32'(ref_source_sel), 32'(m_setup[5:4]));
      chk("chan", 32'(channel_on), 32'(ch));
   endtask

   task automatic rdchk(input logic [5:0] a, input int n);
      logic [31:0] d;
      logic [5:0]  b;
      logic [37:0] e;
      e = exp_rd(a, status_append_en);
      i_host.rd(a, n, d, b);
      chk("rd_data", d, e[31:0]);
      chk("rd_bits", {26'h0, b}, {26'h0, e[37:32]});
      if (a == RESULT_ADDR) m_rdy_b = 1'b1;
      chk("rdy_b", {31'h0, rdy_b}, {31'h0, m_rdy_b});
   endtask

   // Filter side pulse; data lines invert once released
   task automatic pulse(input logic [23:0] d, input logic [7:0] s);
      @(negedge sys_clk);
      conv_done   = 1'b1;
      conv_data   = d;
      conv_status = s;
      @(negedge sys_clk);
      conv_done   = 1'b0;
      conv_data   = ~d;
      conv_status = ~s;
   endtask

   task automatic store(input logic [23:0] d, input logic [7:0] s);
      m_short = short_word_length;
      m_res   = m_short ? rnd(d) : d;
      m_stat  = s;
      m_rdy_b = 1'b0;
   endtask

   task automatic conv(input logic [23:0] d, input logic [7:0] s);
      logic ok;
      pulse(d, s);
      store(d, s);
      i_host.wait_ready(ok);
      chk("rdy_seen", 32'(ok), 32'h1);
      chk("rdy_low", {31'h0, rdy_b}, 32'h0);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         final_report();
      end
   end

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial begin
      logic [15:0] w;
      void'($urandom(32'h184a));
      repeat (6) @(negedge sys_clk);
      rst_b = 1'b1;
      chk_setup();
      rdchk(SETUP_ADDR, 0);
      rdchk(RESULT_ADDR, 1);
      $display("reset values done");
      for (int i = 0; i < 16; i++) begin
         w = 16'($urandom);
         w[12] = i[0];
         w[11:10] = i[1:0];
         w[9:8] = i[3:2];
         w[5:4] = i[3:2];
         w[3:0] = 4'(i);
         i_host.wr(SETUP_ADDR, w);
         m_setup = w & SETUP_WMASK;
         chk_setup();
         rdchk(SETUP_ADDR, 0);
      end
      // Back to defaults, each buffer pair switched as one
      i_host.wr(SETUP_ADDR, SETUP_RST);
      m_setup = SETUP_RST;
      i_host.wr(6'h05, 16'h0000);
      i_host.wr(RESULT_ADDR, 16'hffff);
      rdchk(6'h05, 0);
      chk_setup();
      $display("setup fields done");
      for (int i = 0; i < 8; i++) begin
         i_host.status_append_en = i[0];
         conv(24'($urandom), 8'($urandom));
         rdchk(RESULT_ADDR, 1 + i);
         rdchk(RESULT_ADDR, 2);
      end
      $display("full results done");
      i_host.short_word_length = 1'b1;
      rdchk(RESULT_ADDR, 1);
      conv(24'hffff80, 8'h5a);
      rdchk(RESULT_ADDR, 1);
      i_host.status_append_en = 1'b1;
      conv(24'h123480, 8'hc3);
      rdchk(RESULT_ADDR, 3);
      conv(24'h12347f, 8'h3c);
      rdchk(RESULT_ADDR, 1);
      i_host.short_word_length = 1'b0;
      $display("short words done");
      conv(24'habcdef, 8'h11);
      fork
         rdchk(RESULT_ADDR, 6);
         begin
            repeat (2) @(negedge sys_clk);
            pulse(24'h654321, 8'h22);
         end
      join
      chk("held", {31'h0, rdy_b}, 32'h1);
      store(24'h654321, 8'h22);
      @(negedge sys_clk);
      chk("late", {31'h0, rdy_b}, 32'h0);
      rdchk(RESULT_ADDR, 1);
      $display("read blocking done");
      final_report();
   end

endmodule
